/* File: core/rcf_reset_cause.sv */
module rcf_reset_cause
    import rcf_pkg::*;
(
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic              hsel,
    input  wire logic [ADDR_W-1:0] haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic              hready,
    input  wire logic [DATA_W-1:0] hwdata,
    output logic      [DATA_W-1:0] hrdata,
    output logic                   hreadyout,
    output logic                   hresp,
    input  wire logic              stack_overflow_event,
    input  wire logic              stack_underflow_event,
    input  wire logic              window_violation_event,
    input  wire logic              watchdog_timeout_event,
    input  wire logic              reset_instruction_event,
    input  wire logic              memory_violation_event,
    input  wire logic              brownout_event_async,
    input  wire logic              external_reset_pin,
    input  wire logic              brownout_ready_async,
    output logic                   software_brownout_enable
);

    // =====================================================================
    // Bus slave
    // =====================================================================
    logic              wr_en;
    logic [DEC_W-1:0]  reg_addr;
    logic [DATA_W-1:0] wr_data;
    logic [DATA_W-1:0] rd_value;

    rcf_ahb_slave u_slave (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hsize     (hsize),
        .hready    (hready),
        .hwdata    (hwdata),
        .rd_value  (rd_value),
        .hrdata    (hrdata),
        .hreadyout (hreadyout),
        .hresp     (hresp),
        .wr_en     (wr_en),
        .reg_addr  (reg_addr),
        .wr_data   (wr_data)
    );

    // =====================================================================
    // Pin-side inputs
    // =====================================================================
    logic [2:0] async_bus;
    logic [2:0] sync_bus;
    logic       brownout_sync;
    logic       pin_sync;
    logic       bor_ready_sync;
    logic       pin_prev_q;
    logic       brownout_prev_q;
    logic       pin_reset_hit;
    logic       brownout_hit;

    assign async_bus = {brownout_event_async, external_reset_pin,
                        brownout_ready_async};

    rcf_sync #(
        .W         (3),
        .RST_VALUE ({1'h0, PIN_IDLE_LEVEL, 1'h0})
    ) u_sync (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .async_in (async_bus),
        .sync_out (sync_bus)
    );

    assign brownout_sync  = sync_bus[2];
    assign pin_sync       = sync_bus[1];
    assign bor_ready_sync = sync_bus[0];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_prev_q      <= PIN_IDLE_LEVEL;
            brownout_prev_q <= 1'h0;
        end else begin
            pin_prev_q      <= pin_sync;
            brownout_prev_q <= brownout_sync;
        end
    end

    // Pin is active low; a press counts once, on its falling edge
    assign pin_reset_hit = pin_prev_q && !pin_sync;
    assign brownout_hit  = brownout_sync && !brownout_prev_q;

    // =====================================================================
    // Register decode
    // =====================================================================
    function automatic logic hit(input logic [DEC_W-1:0] a,
                                 input logic [DEC_W-1:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    logic wr_main;
    logic wr_mem;
    logic wr_borctl;

    assign wr_main   = wr_en && hit(reg_addr, OFS_MAIN);
    assign wr_mem    = wr_en && hit(reg_addr, OFS_MEMORY);
    assign wr_borctl = wr_en && hit(reg_addr, OFS_BORCTL);

    // =====================================================================
    // Main reset-cause flags
    // =====================================================================
    logic [FLAG_W-1:0] main_q;
    logic [FLAG_W-1:0] main_d;

    // Writes only store; nothing here feeds a reset request
    always_comb begin
        main_d = main_q;
        if (wr_main) begin
            main_d = wr_data[FLAG_W-1:0];
        end
        // Hardware terms applied after the write so they win
        if (brownout_hit) begin
            main_d[FLAG_W-1:2]   = MAIN_UPPER_INIT;
            main_d[BIT_BROWNOUT] = 1'h0;
        end
        if (stack_overflow_event) begin
            main_d[BIT_STACK_OVF] = 1'h1;
        end
        if (stack_underflow_event) begin
            main_d[BIT_STACK_UNF] = 1'h1;
        end
        if (window_violation_event) begin
            main_d[BIT_WIN_VIOL] = 1'h0;
        end
        if (watchdog_timeout_event) begin
            main_d[BIT_WDT_TOUT] = 1'h0;
        end
        if (pin_reset_hit) begin
            main_d[BIT_PIN_RST] = 1'h0;
        end
        if (reset_instruction_event) begin
            main_d[BIT_RST_INSTR] = 1'h0;
        end
    end

    // Only a write or the bits named by a cause move; others hold
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            main_q <= MAIN_POR_VALUE;
        end else begin
            main_q <= main_d;
        end
    end

    // =====================================================================
    // Memory violation flag
    // =====================================================================
    logic mem_flag_q;
    logic mem_flag_d;

    always_comb begin
        mem_flag_d = mem_flag_q;
        if (wr_mem) begin
            mem_flag_d = wr_data[BIT_MEM_VIOL];
        end
        if (brownout_hit) begin
            mem_flag_d = MEM_FLAG_INIT;
        end
        if (memory_violation_event) begin
            mem_flag_d = 1'h0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mem_flag_q <= MEM_FLAG_INIT;
        end else begin
            mem_flag_q <= mem_flag_d;
        end
    end

    // =====================================================================
    // Brown-out control
    // =====================================================================
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            software_brownout_enable <= SW_BOR_EN_INIT;
        end else if (wr_borctl) begin
            software_brownout_enable <= wr_data[BIT_SW_BOR_EN];
        end
    end

    // =====================================================================
    // Read mux
    // =====================================================================
    logic [FLAG_W-1:0] mem_word;
    logic [FLAG_W-1:0] borctl_word;

    always_comb begin
        mem_word                   = '0;
        mem_word[BIT_MEM_VIOL]     = mem_flag_q;
        borctl_word                = '0;
        borctl_word[BIT_SW_BOR_EN] = software_brownout_enable;
        borctl_word[BIT_BOR_READY] = bor_ready_sync;
        rd_value                   = '0;
        if (hit(reg_addr, OFS_MAIN)) begin
            rd_value[FLAG_W-1:0] = main_q;
        end else if (hit(reg_addr, OFS_MEMORY)) begin
            rd_value[FLAG_W-1:0] = mem_word;
        end else if (hit(reg_addr, OFS_BORCTL)) begin
            rd_value[FLAG_W-1:0] = borctl_word;
        end
    end

    // =====================================================================
    // Checks
    // =====================================================================
    AST_STACK_OVF: assert property (
        @(posedge hclk) disable iff (!hresetn)
        stack_overflow_event |=> main_q[BIT_STACK_OVF])
        else $error("stack overflow flag not set");

    AST_STACK_UNF: assert property (
        @(posedge hclk) disable iff (!hresetn)
        stack_underflow_event |=> main_q[BIT_STACK_UNF])
        else $error("stack underflow flag not set");

    AST_WIN_VIOL: assert property (
        @(posedge hclk) disable iff (!hresetn)
        window_violation_event |=> !main_q[BIT_WIN_VIOL])
        else $error("window violation flag not cleared");

    AST_WDT_TOUT: assert property (
        @(posedge hclk) disable iff (!hresetn)
        watchdog_timeout_event |=> !main_q[BIT_WDT_TOUT])
        else $error("watchdog time-out flag not cleared");

    AST_PIN_RST: assert property (
        @(posedge hclk) disable iff (!hresetn)
        $fell(pin_sync) |=> !main_q[BIT_PIN_RST])
        else $error("pin reset flag not cleared");

    AST_RST_INSTR: assert property (
        @(posedge hclk) disable iff (!hresetn)
        reset_instruction_event |=> !main_q[BIT_RST_INSTR])
        else $error("reset instruction flag not cleared");

    AST_BROWNOUT: assert property (
        @(posedge hclk) disable iff (!hresetn)
        $rose(brownout_sync) |=> main_q[FLAG_W-1:2] == MAIN_UPPER_INIT
            && !main_q[BIT_BROWNOUT] && mem_flag_q
            && main_q[BIT_POWER_ON] == $past(main_q[BIT_POWER_ON]))
        else $error("brown-out load wrong");

    AST_MEM_VIOL: assert property (
        @(posedge hclk) disable iff (!hresetn)
        memory_violation_event |=> !mem_flag_q)
        else $error("memory violation flag not cleared");

    AST_MEM_ZERO: assert property (
        @(posedge hclk) disable iff (!hresetn)
        hit(reg_addr, OFS_MEMORY) |-> (rd_value & ~DATA_W'(MEM_IMPL_MASK))
            == '0)
        else $error("unimplemented memory bits not zero");

    AST_WRITE_STORE: assert property (
        @(posedge hclk) disable iff (!hresetn)
        wr_main && !stack_overflow_event && !stack_underflow_event
            && !window_violation_event && !watchdog_timeout_event
            && !pin_reset_hit && !reset_instruction_event && !brownout_hit
        |=> main_q == $past(wr_data[FLAG_W-1:0]))
        else $error("main register write not stored");

    AST_HOLD: assert property (
        @(posedge hclk) disable iff (!hresetn)
        !wr_main && !stack_overflow_event && !stack_underflow_event
            && !window_violation_event && !watchdog_timeout_event
            && !pin_reset_hit && !reset_instruction_event && !brownout_hit
        |=> $stable(main_q))
        else $error("main flags changed without cause");

    AST_HW_WINS: assert property (
        @(posedge hclk) disable iff (!hresetn)
        wr_mem && memory_violation_event |=> !mem_flag_q)
        else $error("firmware write beat hardware update");

    AST_BORCTL_READ: assert property (
        @(posedge hclk) disable iff (!hresetn)
        hit(reg_addr, OFS_BORCTL) |-> rd_value[BIT_SW_BOR_EN]
            == software_brownout_enable
            && rd_value[BIT_BOR_READY] == bor_ready_sync)
        else $error("brown-out control read wrong");

endmodule : rcf_reset_cause

/* File: core/rcf_pkg.sv */
package rcf_pkg;

    // =====================================================================
    // Bus geometry
    // =====================================================================
    localparam int          DATA_W        = 32;
    localparam int          ADDR_W        = 32;
    localparam int          DEC_W         = 12;
    localparam int          FLAG_W        = 8;
    localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
    localparam logic        HRESP_OKAY    = 1'h0;

    // =====================================================================
    // Register byte offsets
    // =====================================================================
    localparam logic [DEC_W-1:0] OFS_MAIN   = 12'h000;
    localparam logic [DEC_W-1:0] OFS_MEMORY = 12'h004;
    localparam logic [DEC_W-1:0] OFS_BORCTL = 12'h008;

    // =====================================================================
    // Field positions, main reset-cause register
    // =====================================================================
    localparam int BIT_STACK_OVF  = 7;
    localparam int BIT_STACK_UNF  = 6;
    localparam int BIT_WIN_VIOL   = 5;
    localparam int BIT_WDT_TOUT   = 4;
    localparam int BIT_PIN_RST    = 3;
    localparam int BIT_RST_INSTR  = 2;
    localparam int BIT_POWER_ON   = 1;
    localparam int BIT_BROWNOUT   = 0;

    // Memory violation and brown-out control fields
    localparam int BIT_MEM_VIOL   = 1;
    localparam int BIT_SW_BOR_EN  = 7;
    localparam int BIT_BOR_READY  = 0;

    // =====================================================================
    // Reset values
    // =====================================================================
    // Power-on: upper six 0,0,1,1,1,1; power-on flag 0; brown-out flag 1
    localparam logic [FLAG_W-1:0] MAIN_POR_VALUE  = 8'h3d;
    // Loaded into bits 7..2 on a brown-out
    localparam logic [5:0]        MAIN_UPPER_INIT = 6'h0f;
    localparam logic [FLAG_W-1:0] MEM_IMPL_MASK   = 8'h02;
    localparam logic              MEM_FLAG_INIT   = 1'h1;
    localparam logic              SW_BOR_EN_INIT  = 1'h1;
    localparam logic              PIN_IDLE_LEVEL  = 1'h1;

endpackage : rcf_pkg

/* File: core/rcf_sync.sv */
module rcf_sync
    import rcf_pkg::*;
#(
    parameter int             W         = 1,
    parameter logic [W-1:0]   RST_VALUE = '0
) (
    input  wire logic         hclk,
    input  wire logic         hresetn,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    // =====================================================================
    // Two-stage synchroniser; first stage feeds only the second
    // =====================================================================
    logic [W-1:0] meta_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta_q   <= RST_VALUE;
            sync_out <= RST_VALUE;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule : rcf_sync

/* File: core/rcf_ahb_slave.sv */
module rcf_ahb_slave
    import rcf_pkg::*;
(
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic              hsel,
    input  wire logic [ADDR_W-1:0] haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic              hready,
    input  wire logic [DATA_W-1:0] hwdata,
    input  wire logic [DATA_W-1:0] rd_value,
    output logic      [DATA_W-1:0] hrdata,
    output logic                   hreadyout,
    output logic                   hresp,
    output logic                   wr_en,
    output logic      [DEC_W-1:0]  reg_addr,
    output logic      [DATA_W-1:0] wr_data
);

    // =====================================================================
    // Address phase capture
    // =====================================================================
    logic accept;
    logic wr_phase_q;
    logic rd_wait_q;

    // Only whole-word transfers are expected; hsize is not checked
    assign accept = hsel && hready && htrans == HTRANS_NONSEQ;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_phase_q <= 1'h0;
            rd_wait_q  <= 1'h0;
            reg_addr   <= '0;
        end else begin
            wr_phase_q <= accept && hwrite;
            rd_wait_q  <= accept && !hwrite;
            if (accept) begin
                reg_addr <= haddr[DEC_W-1:0];
            end
        end
    end

    // =====================================================================
    // Data phase
    // =====================================================================
    // One wait state on reads so a write just before is always seen
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= '0;
        end else if (rd_wait_q) begin
            hrdata <= rd_value;
        end
    end

    assign hreadyout = !rd_wait_q;
    assign hresp     = HRESP_OKAY;
    assign wr_en     = wr_phase_q;
    assign wr_data   = hwdata;

endmodule : rcf_ahb_slave

/* File: test/rcf_reset_cause_tb.sv */
module rcf_reset_cause_tb
    import rcf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    // =====================================================================
    // Signals
    // =====================================================================
    typedef struct packed {
        logic [7:0] main0;
        logic [7:0] mem0;
        logic [2:0] cause;
        logic [7:0] main1;
        logic [7:0] mem1;
    } rcf_row_s;

    logic              hclk;
    logic              hresetn;
    logic              hsel;
    logic [ADDR_W-1:0] haddr;
    logic [1:0]        htrans;
    logic              hwrite;
    logic [2:0]        hsize;
    logic [DATA_W-1:0] hwdata;
    logic [DATA_W-1:0] hrdata;
    logic              hreadyout;
    logic              hresp;
    logic [5:0]        ev;
    logic [5:0]        ev_data;
    logic              bor_async;
    logic              pin_n;
    logic              bor_ready;
    logic              sw_bor_en;
    logic [DATA_W-1:0] rd;
    int                bad_count;
    int                total_checks;

    // Stack ovf, stack unf, window, wdt, reset instr, memory violation, pin, brown-out
    rcf_row_s rows [0:7] = '{
        '{8'h3f, 8'h00, 3'd0, 8'hbf, 8'h00},
        '{8'h3f, 8'h02, 3'd1, 8'h7f, 8'h02},
        '{8'h3f, 8'h02, 3'd2, 8'h1f, 8'h02},
        '{8'h3f, 8'h02, 3'd3, 8'h2f, 8'h02},
        '{8'h3f, 8'h02, 3'd4, 8'h3b, 8'h02},
        '{8'h3f, 8'h02, 3'd5, 8'h3f, 8'h00},
        '{8'hff, 8'h02, 3'd6, 8'hf7, 8'h02},
        '{8'hc0, 8'h00, 3'd7, 8'h3c, 8'h02}
    };

    rcf_reset_cause u_rcf_reset_cause (
        .hclk                    (hclk),
        .hresetn                 (hresetn),
        .hsel                    (hsel),
        .haddr                   (haddr),
        .htrans                  (htrans),
        .hwrite                  (hwrite),
        .hsize                   (hsize),
        .hready                  (hreadyout),
        .hwdata                  (hwdata),
        .hrdata                  (hrdata),
        .hreadyout               (hreadyout),
        .hresp                   (hresp),
        .stack_overflow_event    (ev[0]),
        .stack_underflow_event   (ev[1]),
        .window_violation_event  (ev[2]),
        .watchdog_timeout_event  (ev[3]),
        .reset_instruction_event (ev[4]),
        .memory_violation_event  (ev[5]),
        .brownout_event_async    (bor_async),
        .external_reset_pin      (pin_n),
        .brownout_ready_async    (bor_ready),
        .software_brownout_enable(sw_bor_en)
    );

    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end

    // =====================================================================
    // Tasks
    // =====================================================================
    task automatic close_out;
        if (bad_count == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : close_out

    task automatic check(input string name, input logic [DATA_W-1:0] seen,
                         input logic [DATA_W-1:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // Ready is sampled with the values from before the edge
    task automatic wait_ready;
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 20);
        if (n >= 20) begin
            bad_count++;
            close_out();
        end
    endtask : wait_ready

    // ev_data rides along with the data phase to force a collision
    task automatic bus_xfer(input logic wr, input logic [DEC_W-1:0] a,
                            input logic [DATA_W-1:0] wd);
        hsel   <= 1'b1;
        haddr  <= ADDR_W'(a);
        hwrite <= wr;
        htrans <= HTRANS_NONSEQ;
        hsize  <= 3'h2;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= wd;
        if (ev_data != 6'h00) begin
            ev <= ev_data;
        end
        wait_ready();
        rd = hrdata;
        if (ev_data != 6'h00) begin
            ev <= 6'h00;
        end
    endtask : bus_xfer

    task automatic rd_check(input string name, input logic [DEC_W-1:0] a,
                            input logic [DATA_W-1:0] exp);
        bus_xfer(1'b0, a, '0);
        check(name, rd, exp);
    endtask : rd_check

    // Pin and brown-out go through the synchronisers, hence the hold
    task automatic fire(input logic [2:0] cause);
        if (cause < 3'd6) begin
            ev <= 6'h01 << cause;
            @(posedge hclk);
            ev <= 6'h00;
        end else if (cause == 3'd6) begin
            pin_n <= 1'b0;
            repeat (4) @(posedge hclk);
            pin_n <= 1'b1;
        end else begin
            bor_async <= 1'b1;
            repeat (4) @(posedge hclk);
            bor_async <= 1'b0;
        end
        repeat (6) @(posedge hclk);
    endtask : fire

    // =====================================================================
    // Main sequence
    // =====================================================================
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = '0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = '0;
        ev = 6'h00;
        ev_data = 6'h00;
        bor_async = 1'b0;
        pin_n = PIN_IDLE_LEVEL;
        bor_ready = 1'b1;
        bad_count = 0;
        total_checks = 0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (4) @(posedge hclk);
        for (int i = 0; i < 8; i++) begin
            bus_xfer(1'b1, OFS_MAIN, 32'(rows[i].main0));
            bus_xfer(1'b1, OFS_MEMORY, 32'(rows[i].mem0));
            fire(rows[i].cause);
            rd_check("main", OFS_MAIN, 32'(rows[i].main1));
            rd_check("memory", OFS_MEMORY, 32'(rows[i].mem1));
        end
        // Firmware may write any value; active values start nothing
        bus_xfer(1'b1, OFS_MAIN, 32'h000000c0);
        rd_check("main_wr", OFS_MAIN, 32'h000000c0);
        bus_xfer(1'b1, OFS_MAIN, 32'hffffff3f);
        rd_check("main_wr2", OFS_MAIN, 32'h0000003f);
        bus_xfer(1'b1, OFS_MEMORY, 32'hffffffff);
        rd_check("mem_wr", OFS_MEMORY, 32'h00000002);
        bus_xfer(1'b1, OFS_MEMORY, 32'h00000000);
        rd_check("mem_wr0", OFS_MEMORY, 32'h00000000);
        bus_xfer(1'b1, OFS_BORCTL, 32'hffffffff);
        rd_check("ctrl", OFS_BORCTL, 32'h00000081);
        bus_xfer(1'b1, OFS_BORCTL, 32'h00000000);
        // Enable flop loads on the edge that ends the write; look one later
        @(posedge hclk);
        check("sw_bor_en", {31'h0, sw_bor_en}, 32'h0);
        bor_ready <= 1'b0;
        repeat (5) @(posedge hclk);
        rd_check("ctrl_rdy", OFS_BORCTL, 32'h00000000);
        bus_xfer(1'b1, 12'h00c, 32'hffffffff);
        rd_check("unmapped", 12'h00c, 32'h00000000);
        check("hresp", {31'h0, hresp}, 32'h0);
        // Hardware beats the write landing in the same cycle
        bus_xfer(1'b1, OFS_MAIN, 32'h0000003f);
        ev_data = 6'h01;
        bus_xfer(1'b1, OFS_MAIN, 32'h0000003f);
        ev_data = 6'h20;
        bus_xfer(1'b1, OFS_MEMORY, 32'h00000002);
        ev_data = 6'h00;
        rd_check("collide", OFS_MAIN, 32'h000000bf);
        rd_check("collide_m", OFS_MEMORY, 32'h00000000);
        // Second power-on reset in mid-run
        bor_ready <= 1'b1;
        hresetn <= 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (4) @(posedge hclk);
        check("sw_bor_rst", {31'h0, sw_bor_en}, 32'h1);
        rd_check("main_rst", OFS_MAIN, 32'(MAIN_POR_VALUE));
        rd_check("mem_rst", OFS_MEMORY, 32'h00000002);
        rd_check("ctrl_rst", OFS_BORCTL, 32'h00000081);
        close_out();
    end

endmodule : rcf_reset_cause_tb
